// *** hdl/aux_sup_pkg.sv ***
package aux_sup_pkg;
  // ==========================================
  // Timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BRAKE_MAX_SEC = 15;
  localparam int unsigned BRAKE_MAX_CYC = BRAKE_MAX_SEC * CLK_HZ;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  // ==========================================
  // Settings
  localparam logic DUTY_LIMIT_RST = 1'h1;
  localparam logic [4:0] DUTY_RATE_RST = 5'h0A;
  localparam logic [4:0] DUTY_RATE_MAX = 5'h1E;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [4:0] FUNC_FAULT_OUT = 5'h11;
  localparam logic [4:0] FUNC_FAN_ALARM = 5'h12;
  localparam logic FAN_ACT_CONTINUE = 1'h0;
  localparam logic FAN_ACT_STOP = 1'h1;
  localparam int unsigned NUM_FANS = 2;

  // Sequence phase
  typedef enum logic [1:0] {
    PH_ACC = 2'h0,
    PH_DEC = 2'h1,
    PH_STOP = 2'h3
  } phase_e;

  // One motor parameter set
  typedef struct packed {
    logic [15:0] accel_time;
    logic [15:0] decel_time;
    logic [15:0] base_freq;
    logic [1:0] vf_pattern;
    logic [7:0] fwd_boost;
    logic [7:0] rev_boost;
    logic [7:0] stall_level;
    logic [7:0] eth_1min;
    logic [7:0] eth_cont;
    logic [7:0] rated_current;
  } motor_set_s;
endpackage

// *** hdl/ms_tick.sv ***
`timescale 1ns/1ns
`default_nettype none
module ms_tick (
  input wire logic clk,
  input wire logic nrst,
  output logic tick
);
  import aux_sup_pkg::*;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  // Millisecond divider
  always_comb begin
    cnt_d = (cnt_q == 16'(MS_CYC - 1)) ? 16'h0000 : cnt_q + 16'h0001;
  end
  // Divider register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // One-cycle pulse at the end of each millisecond
  assign tick = (cnt_q == 16'(MS_CYC - 1));
endmodule
`default_nettype wire

// *** hdl/drive_aux_supervisor.sv ***
`timescale 1ns/1ns
`default_nettype none
module drive_aux_supervisor #(
  parameter int unsigned BRAKE_LIMIT_CYC = aux_sup_pkg::BRAKE_MAX_CYC
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic BRAKING_DUTY_LIMIT_SELECT,
  input wire logic [4:0] BRAKING_DUTY_RATE,
  input wire logic BRAKE_REQ,
  input wire aux_sup_pkg::phase_e PHASE,
  input wire logic SEQ_START,
  input wire logic FAN_MODE,
  input wire logic POWER_ON,
  input wire logic MAIN_UNDERVOLT,
  input wire logic RUN_CMD,
  input wire logic HEATSINK_HOT,
  input wire logic [aux_sup_pkg::NUM_FANS-1:0] FAN_OK,
  input wire logic FAN_FAULT_ACTION,
  input wire logic FAULT_RESET,
  input wire logic [4:0] AUX_OUTPUT_FUNCTION_A,
  input wire logic [4:0] AUX_OUTPUT_FUNCTION_B,
  input wire logic ALT_ASSIGNED,
  input wire logic ALT_INPUT_ON,
  input wire aux_sup_pkg::motor_set_s SET1,
  input wire aux_sup_pkg::motor_set_s SET2,
  input wire logic [1:0] VF_CURVE_SELECT,
  output logic BRAKE_ON,
  output logic [6:0] BRAKING_DUTY_PERCENT,
  output logic FAN_ON,
  output logic FAN_FAULT,
  output logic FAN_TRIP,
  output logic FAN_MSG,
  output logic RUN_ENABLE,
  output logic AUX_OUT_A,
  output logic AUX_OUT_B,
  output logic ALT_VISIBLE,
  output logic ALT_ACTIVE,
  output aux_sup_pkg::motor_set_s ACTIVE_SET,
  output logic [1:0] ACTIVE_VF_CURVE
);
  import aux_sup_pkg::*;

  typedef struct packed {
    logic [31:0] t_acc;
    logic [31:0] t_dec;
    logic [31:0] t_stop;
    logic [6:0] duty;
    logic [31:0] brake_cnt;
    logic brake;
    logic fan;
    logic fan_fault;
    logic trip;
    logic alt;
    motor_set_s set;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic tick;
  logic [4:0] rate_eff;
  logic [38:0] num;
  logic [31:0] den;
  logic limit_hit;
  logic fault_now;

  // Time base for sequence phase timing
  ms_tick u_tick (
    .clk(CORE_CLK),
    .nrst(NRST),
    .tick(tick)
  );

  // Duty rate clamped to its legal span
  assign rate_eff = (BRAKING_DUTY_RATE > DUTY_RATE_MAX) ? DUTY_RATE_MAX : BRAKING_DUTY_RATE;
  assign num = {s_q.t_dec, 7'h00} - {2'h0, s_q.t_dec, 5'h00} + {5'h00, s_q.t_dec, 2'h0};
  assign den = s_q.t_acc + s_q.t_dec + s_q.t_stop;
  assign limit_hit = BRAKING_DUTY_LIMIT_SELECT && (s_q.duty >= {2'h0, rate_eff});
  assign fault_now = ~&FAN_OK;

  // Next state
  always_comb begin
    s_d = s_q;
    // Phase time accumulation, cleared at each new sequence
    if (SEQ_START) begin
      s_d.t_acc = 32'h0;
      s_d.t_dec = 32'h0;
      s_d.t_stop = 32'h0;
    end else if (tick) begin
      case (PHASE)
        PH_ACC: s_d.t_acc = s_q.t_acc + 32'h1;
        PH_DEC: s_d.t_dec = s_q.t_dec + 32'h1;
        PH_STOP: s_d.t_stop = s_q.t_stop + 32'h1;
        default: s_d.t_acc = s_q.t_acc;
      endcase
    end
    // Duty percent by integer division
    if (den == 32'h0) begin
      s_d.duty = 7'h00;
    end else if (num / {7'h00, den} > 39'(PCT_FULL)) begin
      s_d.duty = PCT_FULL;
    end else begin
      s_d.duty = 7'(num / {7'h00, den});
    end
    // Continuous braking window
    if (BRAKE_REQ) begin
      if (s_q.brake_cnt < BRAKE_LIMIT_CYC) begin
        s_d.brake_cnt = s_q.brake_cnt + 32'h1;
      end
    end else begin
      s_d.brake_cnt = 32'h0;
    end
    s_d.brake = BRAKE_REQ && !limit_hit && (s_q.brake_cnt < BRAKE_LIMIT_CYC);
    // Fan drive
    if (!POWER_ON) begin
      s_d.fan = 1'b0;
    end else if (FAN_MODE == 1'b0) begin
      s_d.fan = !MAIN_UNDERVOLT;
    end else begin
      s_d.fan = RUN_CMD || HEATSINK_HOT;
    end
    // Fan fault: a new loss wins over the reset
    s_d.fan_fault = fault_now || (s_q.fan_fault && !FAULT_RESET);
    if (fault_now && FAN_FAULT_ACTION == FAN_ACT_STOP) begin
      s_d.trip = 1'b1;
    end else if (FAULT_RESET) begin
      s_d.trip = 1'b0;
    end
    // Motor set selection
    s_d.alt = ALT_ASSIGNED && ALT_INPUT_ON;
    s_d.set = s_d.alt ? SET2 : SET1;
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign BRAKE_ON = s_q.brake;
  assign BRAKING_DUTY_PERCENT = s_q.duty;
  assign FAN_ON = s_q.fan;
  assign FAN_FAULT = s_q.fan_fault;
  assign FAN_TRIP = s_q.trip;
  assign FAN_MSG = s_q.trip;
  assign RUN_ENABLE = !s_q.trip;
  assign AUX_OUT_A = (AUX_OUTPUT_FUNCTION_A == FUNC_FAN_ALARM && s_q.fan_fault)
    || (AUX_OUTPUT_FUNCTION_A == FUNC_FAULT_OUT && s_q.trip);
  assign AUX_OUT_B = (AUX_OUTPUT_FUNCTION_B == FUNC_FAN_ALARM && s_q.fan_fault)
    || (AUX_OUTPUT_FUNCTION_B == FUNC_FAULT_OUT && s_q.trip);
  assign ALT_VISIBLE = ALT_ASSIGNED;
  assign ALT_ACTIVE = s_q.alt;
  assign ACTIVE_SET = s_q.set;
  assign ACTIVE_VF_CURVE = VF_CURVE_SELECT;

  // ==========================================
  // Checks
  a_brake_window: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    s_q.brake_cnt >= BRAKE_LIMIT_CYC |=> !BRAKE_ON)
    else $error("braking beyond continuous limit");
  a_duty_suppress: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    limit_hit |=> !BRAKE_ON)
    else $error("braking while duty limit reached");
  a_nolimit_brake: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !BRAKING_DUTY_LIMIT_SELECT && BRAKE_REQ && s_q.brake_cnt == 32'h0 |=> BRAKE_ON)
    else $error("braking blocked without limit");
  a_fan_mode0: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    POWER_ON && !FAN_MODE && !MAIN_UNDERVOLT |=> FAN_ON)
    else $error("fan off in mode 0");
  a_fan_mode1: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    POWER_ON && FAN_MODE && !RUN_CMD && !HEATSINK_HOT |=> !FAN_ON)
    else $error("fan on without run");
  a_fan_hot: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    POWER_ON && FAN_MODE && HEATSINK_HOT |=> FAN_ON)
    else $error("fan off while hot");
  a_fan_detect: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    fault_now |=> FAN_FAULT)
    else $error("fan loss missed");
  a_fan_continue: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    fault_now && !FAN_FAULT_ACTION && !FAN_TRIP |=> RUN_ENABLE)
    else $error("stopped under continue action");
  a_fan_trip: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    fault_now && FAN_FAULT_ACTION |=> !RUN_ENABLE && FAN_MSG)
    else $error("no stop on fan trip");
  a_alarm_out: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    FAN_FAULT && AUX_OUTPUT_FUNCTION_A == FUNC_FAN_ALARM |-> AUX_OUT_A)
    else $error("alarm output missing");
  a_trip_out: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    FAN_TRIP && AUX_OUTPUT_FUNCTION_B == FUNC_FAULT_OUT |-> AUX_OUT_B)
    else $error("fault output missing");
  a_alt_select: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !(ALT_ASSIGNED && ALT_INPUT_ON) |=> ACTIVE_SET == $past(SET1))
    else $error("second set without select");
  a_alt_apply: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    ALT_ASSIGNED && ALT_INPUT_ON |=> ALT_ACTIVE && ACTIVE_SET == $past(SET2))
    else $error("second set not applied");
  a_rate_clamp: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    BRAKING_DUTY_RATE > DUTY_RATE_MAX |-> rate_eff == DUTY_RATE_MAX)
    else $error("duty rate not clamped");
  a_duty_full: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    s_q.t_dec != 32'h0 && s_q.t_acc == 32'h0 && s_q.t_stop == 32'h0
    |=> BRAKING_DUTY_PERCENT == PCT_FULL)
    else $error("duty not full for decel only");
  a_duty_zero: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    s_q.t_dec == 32'h0 |=> BRAKING_DUTY_PERCENT == 7'h00)
    else $error("duty without decel time");
  a_duty_range: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    BRAKING_DUTY_PERCENT <= PCT_FULL)
    else $error("duty above full scale");
  a_alt_hidden: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !ALT_ASSIGNED |=> !ALT_ACTIVE && ACTIVE_SET == $past(SET1))
    else $error("second set used while unassigned");
  a_alarm_out_b: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    FAN_FAULT && AUX_OUTPUT_FUNCTION_B == FUNC_FAN_ALARM |-> AUX_OUT_B)
    else $error("alarm output b missing");
  a_trip_out_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    FAN_TRIP && AUX_OUTPUT_FUNCTION_A == FUNC_FAULT_OUT |-> AUX_OUT_A)
    else $error("fault output a missing");
  a_fan_poweroff: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !POWER_ON |=> !FAN_ON)
    else $error("fan on at power off");
  a_fault_hold: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    FAN_FAULT && !FAULT_RESET |=> FAN_FAULT)
    else $error("fan fault dropped without reset");
  a_trip_hold: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    FAN_TRIP && !FAULT_RESET |=> FAN_TRIP)
    else $error("fan trip dropped without reset");
endmodule
`default_nettype wire

// *** verif/fan_bank.sv ***
`timescale 1ns/1ns
`default_nettype none
module fan_bank (
  input wire logic [aux_sup_pkg::NUM_FANS-1:0] fail_mask,
  output logic [aux_sup_pkg::NUM_FANS-1:0] fan_ok
);
  import aux_sup_pkg::*;
  // ==========
  // Fans
  // A failed fan reports loss; healthy fans report good
  always_comb fan_ok = ~fail_mask;
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import aux_sup_pkg::*;
  localparam int unsigned LIM = 50;
  logic clk, nrst, lim_sel, brk_req, seq_start, fan_mode, pwr, uv, run, hot;
  logic act, frst, alt_asg, alt_on, brk_on, fan_on, flt, trip, msg, run_en;
  logic out_a, out_b, alt_vis, alt_act;
  logic [4:0] rate, fa, fb;
  logic [1:0] fail, fan_ok, vf, vf_out;
  logic [6:0] pct;
  phase_e ph;
  motor_set_s s1, s2, set_out;
  int failures, cmp_count, cyc;
  // ==========
  // Block and fans
  drive_aux_supervisor #(.BRAKE_LIMIT_CYC(LIM)) dut_u (
    .CORE_CLK(clk), .NRST(nrst), .BRAKING_DUTY_LIMIT_SELECT(lim_sel),
    .BRAKING_DUTY_RATE(rate), .BRAKE_REQ(brk_req), .PHASE(ph), .SEQ_START(seq_start),
    .FAN_MODE(fan_mode), .POWER_ON(pwr), .MAIN_UNDERVOLT(uv), .RUN_CMD(run),
    .HEATSINK_HOT(hot), .FAN_OK(fan_ok), .FAN_FAULT_ACTION(act), .FAULT_RESET(frst),
    .AUX_OUTPUT_FUNCTION_A(fa), .AUX_OUTPUT_FUNCTION_B(fb), .ALT_ASSIGNED(alt_asg),
    .ALT_INPUT_ON(alt_on), .SET1(s1), .SET2(s2), .VF_CURVE_SELECT(vf),
    .BRAKE_ON(brk_on), .BRAKING_DUTY_PERCENT(pct), .FAN_ON(fan_on), .FAN_FAULT(flt),
    .FAN_TRIP(trip), .FAN_MSG(msg), .RUN_ENABLE(run_en), .AUX_OUT_A(out_a),
    .AUX_OUT_B(out_b), .ALT_VISIBLE(alt_vis), .ALT_ACTIVE(alt_act),
    .ACTIVE_SET(set_out), .ACTIVE_VF_CURVE(vf_out));
  fan_bank fans_u (.fail_mask(fail), .fan_ok(fan_ok));
  // ==========
  // Clock and cycle limit
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ==========
  // Helpers
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [103:0] e, input logic [103:0] g);
    cmp_count++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic brake_cap();
    brk_req = 1'h1;
    step(2);
    chk("brake_on", 1'h1, brk_on);
    step(LIM - 2);
    chk("brake_on", 1'h1, brk_on);
    step(1);
    chk("brake_on", 1'h0, brk_on);
    step(2);
    chk("brake_on", 1'h0, brk_on);
    brk_req = 1'h0;
    step(1);
    brk_req = 1'h1;
    step(2);
    chk("brake_on", 1'h1, brk_on);
    brk_req = 1'h0;
  endtask
  task automatic duty_limit();
    lim_sel = 1'h1;
    ph = PH_DEC;
    seq_start = 1'h1;
    step(1);
    seq_start = 1'h0;
    brk_req = 1'h1;
    step(2);
    chk("brake_on", 1'h1, brk_on);
    brk_req = 1'h0;
    step(50005);
    chk("duty_pct", PCT_FULL, pct);
    brk_req = 1'h1;
    step(2);
    chk("brake_on", 1'h0, brk_on);
    rate = 5'h1F;
    step(1);
    chk("brake_on", 1'h0, brk_on);
    rate = DUTY_RATE_RST;
    lim_sel = 1'h0;
    step(2);
    chk("brake_on", 1'h1, brk_on);
    brk_req = 1'h0;
    ph = PH_STOP;
  endtask
  task automatic fan_modes();
    logic e;
    for (int i = 0; i < 32; i++) begin
      {fan_mode, pwr, uv, run, hot} = i[4:0];
      step(2);
      e = fan_mode ? (pwr & (run | hot)) : (pwr & !uv);
      chk("fan_on", e, fan_on);
    end
  endtask
  task automatic fan_fault(input logic a);
    act = a;
    fa = a ? FUNC_FAN_ALARM : FUNC_FAULT_OUT;
    fb = a ? FUNC_FAULT_OUT : FUNC_FAN_ALARM;
    fail = a ? 2'h1 : 2'h2;
    step(2);
    chk("fault", 1'h1, flt);
    chk("trip", a, trip);
    chk("msg", a, msg);
    chk("run_en", !a, run_en);
    chk("out_a", a, out_a);
    chk("out_b", 1'h1, out_b);
    frst = 1'h1;
    step(1);
    frst = 1'h0;
    fail = 2'h0;
    step(1);
    chk("fault", 1'h1, flt);
    chk("trip", a, trip);
    frst = 1'h1;
    step(1);
    frst = 1'h0;
    step(1);
    chk("fault", 1'h0, flt);
    chk("run_en", 1'h1, run_en);
  endtask
  task automatic alt_set();
    run = 1'h0;
    alt_on = 1'h1;
    step(2);
    chk("alt_vis", 1'h0, alt_vis);
    chk("alt_act", 1'h0, alt_act);
    chk("set", s1, set_out);
    chk("vf", vf, vf_out);
    alt_asg = 1'h1;
    step(2);
    chk("alt_vis", 1'h1, alt_vis);
    chk("alt_act", 1'h1, alt_act);
    chk("set", s2, set_out);
    chk("vf", vf, vf_out);
    alt_on = 1'h0;
    step(2);
    chk("set", s1, set_out);
    chk("alt_act", 1'h0, alt_act);
  endtask
  task automatic reset_mid();
    act = 1'h1;
    fail = 2'h1;
    step(2);
    chk("trip", 1'h1, trip);
    nrst = 1'h0;
    step(1);
    chk("trip", 1'h0, trip);
    chk("fault", 1'h0, flt);
    chk("run_en", 1'h1, run_en);
    fail = 2'h0;
    nrst = 1'h1;
    step(2);
    chk("fault", 1'h0, flt);
    chk("run_en", 1'h1, run_en);
  endtask
  // ==========
  // Main sequence
  initial begin
    {nrst, lim_sel, brk_req, seq_start, fan_mode, pwr, uv, run, hot} = '0;
    {act, frst, alt_asg, alt_on, fail} = '0;
    {rate, fa, fb, vf, cyc, failures, cmp_count} = {DUTY_RATE_RST, FUNC_FAN_ALARM,
      FUNC_FAULT_OUT, 2'h2, 96'h0};
    ph = PH_ACC;
    s1 = {7{14'h2A5A}};
    s2 = {7{14'h15A5}};
    step(8);
    nrst = 1'h1;
    step(2);
    brake_cap();
    duty_limit();
    fan_modes();
    fan_fault(1'h0);
    fan_fault(1'h1);
    reset_mid();
    alt_set();
    tally_and_finish();
  end
endmodule
`default_nettype wire
